// *** hw/ufc_bank.sv ***
// Contract
// - four read/write 8-bit flow characters: two resume, two pause.
// - in multidrop mode second pause character is the station address.
// - divisor bytes load 0x01/0x00 (low/high) at power-up only, not on reset pin.
// - modem status low nibble reads zero, upper nibble live; writable nibble resets 0000.
// - power-save gates host bus inputs except control word accesses; modem inputs and reset stay active.
// - special detect compares each data character (address bit clear) with second pause, flags, still stores.
`timescale 1ns/100ps
`include "ufc_consts.svh"
module ufc_bank (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        por_n,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [3:0]  modem_in,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_addr_bit,
  output logic             rx_store,
  output logic             rx_addr_match,
  output logic             tx_out,
  output logic             rts_n,
  output logic             dtr_n,
  output logic             int_out,
  output logic             int_oe,
  output logic             irq_n
);
  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  ufc_rx_if rx ();
  ufc_pkg::ufc_byte_t resume1, resume2, pause1, pause2, divlo, divhi, frac;
  ufc_pkg::ufc_byte_t interrupt_enable_reg, fifo_control_reg, interrupt_status_reg, line_control_reg, modem_control_reg, line_status_reg, msr_wr, scratchpad_reg, enhanced_mode_select_reg, feature_control_reg, enhanced_feature_reg, ctrl;
  logic        wr_pend;
  logic [11:0] wr_addr;
  logic [31:0] next_hrdata;
  logic        pwrsave;
  assign pwrsave = ctrl[`UFC_CTRL_PWRSAVE];
  // host bus inputs are gated off in power-save; the control word stays reachable so it can be left
  wire   bus_ok  = !pwrsave || (haddr == `UFC_OFF_CTRL);
  wire   start   = hsel && htrans[1] && hready && bus_ok;
  wire   rd_go   = start && !hwrite;
  wire   [7:0] wb = hwdata[7:0];
  function automatic logic is_off(input logic [11:0] a, input logic [11:0] o);
    is_off = (a == o);
  endfunction
  wire [7:0] msr_rd = {modem_in, 4'h0};
  wire [7:0] rsel =
    is_off(haddr, `UFC_OFF_RESUME1) ? resume1 : is_off(haddr, `UFC_OFF_RESUME2) ? resume2 :
    is_off(haddr, `UFC_OFF_PAUSE1)  ? pause1  : is_off(haddr, `UFC_OFF_PAUSE2)  ? pause2  :
    is_off(haddr, `UFC_OFF_DIVLO)   ? divlo   : is_off(haddr, `UFC_OFF_DIVHI)   ? divhi   :
    is_off(haddr, `UFC_OFF_FRAC)    ? frac    : is_off(haddr, `UFC_OFF_IER)     ? interrupt_enable_reg     :
    is_off(haddr, `UFC_OFF_FCR)     ? fifo_control_reg     : is_off(haddr, `UFC_OFF_ISR)     ? interrupt_status_reg     :
    is_off(haddr, `UFC_OFF_LCR)     ? line_control_reg     : is_off(haddr, `UFC_OFF_MCR)     ? modem_control_reg     :
    is_off(haddr, `UFC_OFF_LSR)     ? line_status_reg     : is_off(haddr, `UFC_OFF_MSR)     ? msr_rd  :
    is_off(haddr, `UFC_OFF_SPR)     ? scratchpad_reg     : is_off(haddr, `UFC_OFF_ENHANCED_MODE_SELECT_REG)    ? enhanced_mode_select_reg    :
    is_off(haddr, `UFC_OFF_FEATURE_CONTROL_REG)    ? feature_control_reg    : is_off(haddr, `UFC_OFF_EFR)     ? enhanced_feature_reg     :
    is_off(haddr, `UFC_OFF_CTRL)    ? ctrl    : 8'h00;
  assign next_hrdata = rd_go ? {24'h000000, rsel} : hrdata;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  // read data is captured in the address phase, so a read right after a write
  // to the same word returns the value from before that write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      hrdata  <= 32'h00000000;
    end else begin
      wr_pend <= start && hwrite;
      wr_addr <= haddr;
      hrdata  <= next_hrdata;
    end
  end
  function automatic logic wr_at(input logic p, input logic [11:0] a, input logic [11:0] o);
    wr_at = p && (a == o);
  endfunction
  // ----------------------------------------
  // divisor: power-up only
  // ----------------------------------------
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      divlo <= `UFC_RST_DIVLO;
      divhi <= `UFC_RST_DIVHI;
    end else begin
      if (wr_at(wr_pend, wr_addr, `UFC_OFF_DIVLO)) divlo <= wb;
      if (wr_at(wr_pend, wr_addr, `UFC_OFF_DIVHI)) divhi <= wb;
    end
  end
  // ----------------------------------------
  // register bank
  // ----------------------------------------
  assign rx.valid        = rx_valid;
  assign rx.data         = rx_data;
  assign rx.addr_bit     = rx_addr_bit;
  assign rx.pause_two    = pause2;
  assign rx.special_en   = enhanced_feature_reg[`UFC_EFR_SPECIAL];
  assign rx.multidrop_en = ctrl[`UFC_CTRL_MULTIDROP];
  ufc_rx_match u_match (.rx(rx.cmp));
  // a special-matching data character still goes to the receive buffer; address characters are not stored
  assign rx_store      = rx_valid && !rx_addr_bit;
  assign rx_addr_match = rx.addr_hit;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {resume1, resume2, pause1, pause2} <= {4{`UFC_RST_ZERO}};
      {frac, interrupt_enable_reg, fifo_control_reg, line_control_reg, modem_control_reg, enhanced_mode_select_reg, feature_control_reg, enhanced_feature_reg, ctrl} <= {9{`UFC_RST_ZERO}};
      msr_wr <= `UFC_RST_ZERO;
      interrupt_status_reg    <= `UFC_RST_ISR;
      line_status_reg    <= `UFC_RST_LSR;
      scratchpad_reg    <= `UFC_RST_SPR;
    end else begin
      if (wr_at(wr_pend, wr_addr, `UFC_OFF_RESUME1)) resume1 <= wb;
      if (wr_at(wr_pend, wr_addr, `UFC_OFF_RESUME2)) resume2 <= wb;
      if (wr_at(wr_pend, wr_addr, `UFC_OFF_PAUSE1))  pause1  <= wb;
      if (wr_at(wr_pend, wr_addr, `UFC_OFF_PAUSE2))  pause2  <= wb;
      if (wr_at(wr_pend, wr_addr, `UFC_OFF_FRAC))    frac    <= wb;
      if (wr_at(wr_pend, wr_addr, `UFC_OFF_IER))     interrupt_enable_reg     <= wb;
      if (wr_at(wr_pend, wr_addr, `UFC_OFF_FCR))     fifo_control_reg     <= wb;
      if (wr_at(wr_pend, wr_addr, `UFC_OFF_LCR))     line_control_reg     <= wb;
      if (wr_at(wr_pend, wr_addr, `UFC_OFF_MCR))     modem_control_reg     <= wb;
      if (wr_at(wr_pend, wr_addr, `UFC_OFF_MSR))     msr_wr  <= {wb[7:4], 4'h0};
      if (wr_at(wr_pend, wr_addr, `UFC_OFF_SPR))     scratchpad_reg     <= wb;
      if (wr_at(wr_pend, wr_addr, `UFC_OFF_ENHANCED_MODE_SELECT_REG))    enhanced_mode_select_reg    <= wb;
      if (wr_at(wr_pend, wr_addr, `UFC_OFF_FEATURE_CONTROL_REG))    feature_control_reg    <= wb;
      if (wr_at(wr_pend, wr_addr, `UFC_OFF_EFR))     enhanced_feature_reg     <= wb;
      if (wr_at(wr_pend, wr_addr, `UFC_OFF_CTRL))    ctrl    <= wb;
      // detection sets the flag; the set wins over a clearing write in the same cycle
      if (rx.special_hit) begin
        interrupt_status_reg[`UFC_ISR_SPECIAL] <= 1'b1;
      end else if (wr_at(wr_pend, wr_addr, `UFC_OFF_ISR)) begin
        interrupt_status_reg[`UFC_ISR_SPECIAL] <= wb[`UFC_ISR_SPECIAL];
      end
    end
  end
  // ----------------------------------------
  // serial and interrupt pins
  // ----------------------------------------
  // pins idle high; the wired interrupt output floats until software enables it
  assign tx_out  = 1'b1;
  assign rts_n   = !modem_control_reg[`UFC_MCR_RTS];
  assign dtr_n   = !modem_control_reg[`UFC_MCR_DTR];
  wire   int_pend = interrupt_status_reg[`UFC_ISR_SPECIAL] && interrupt_enable_reg[`UFC_IER_SPECIAL];
  assign int_out = int_pend;
  assign int_oe  = modem_control_reg[`UFC_MCR_INTEN];
  assign irq_n   = !int_pend;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence wr_pause2_s;
    wr_pend && wr_addr == `UFC_OFF_PAUSE2;
  endsequence
  sequence rd_pause1_s;
    rd_go && haddr == `UFC_OFF_PAUSE1;
  endsequence
  pause2_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pause2_s |=> pause2 == $past(hwdata[7:0])) else $error("pause2 not written");
  pause1_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pause1_s |=> hrdata[7:0] == $past(pause1)) else $error("pause1 read wrong");
  addr_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_addr_match |-> rx_data == pause2 && ctrl[`UFC_CTRL_MULTIDROP]) else $error("bad address match");
  special_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx.special_hit |=> interrupt_status_reg[`UFC_ISR_SPECIAL] && $past(rx_store)) else $error("special char lost");
  msr_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_go && haddr == `UFC_OFF_MSR) |=> hrdata[3:0] == 4'h0 && hrdata[7:4] == $past(modem_in)) else $error("msr read");
  pwrsave_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (pwrsave && haddr != `UFC_OFF_CTRL) |=> !wr_pend) else $error("bus not gated");
  div_keep_a: assert property (@(posedge hclk) disable iff (!por_n)
    $fell(hresetn) |-> divlo == $past(divlo) && divhi == $past(divhi)) else $error("divisor reset by pin");
  pin_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (modem_control_reg == 8'h00) |-> rts_n && dtr_n && !int_oe && tx_out) else $error("pin idle state");

  // ----------------------------------------
  // checks: writes, status, pins, power-save and divisor
  // ----------------------------------------
  sequence wr_resume1_s;
    wr_pend && wr_addr == `UFC_OFF_RESUME1;
  endsequence
  sequence wr_msr_s;
    wr_pend && wr_addr == `UFC_OFF_MSR;
  endsequence
  sequence wr_isr_clr_s;
    wr_pend && wr_addr == `UFC_OFF_ISR && !rx.special_hit;
  endsequence
  sequence ctrl_req_s;
    hsel && htrans[1] && hready && hwrite && haddr == `UFC_OFF_CTRL;
  endsequence
  resume1_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_resume1_s |=> resume1 == $past(hwdata[7:0])) else $error("resume1 not written");
  bus_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp) else $error("bus answer not okay");
  // the write-only nibble is held apart from the live modem bits that reads show
  msr_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_msr_s |=> msr_wr == {$past(hwdata[7:4]), 4'h0}) else $error("msr write nibble");
  special_store_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx.special_hit |-> rx_store) else $error("special char not stored");
  // software may clear the special flag when no new match arrives with the write
  isr_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_isr_clr_s |=> interrupt_status_reg[`UFC_ISR_SPECIAL] == $past(hwdata[`UFC_ISR_SPECIAL])) else $error("isr clear");
  multidrop_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl[`UFC_CTRL_MULTIDROP] |-> !rx_addr_match) else $error("match without multidrop");
  // a gated read leaves the last read data standing
  pwrsave_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (pwrsave && haddr != `UFC_OFF_CTRL) |=> $stable(hrdata)) else $error("gated read changed data");
  // the control word must stay reachable or power-save could never be left
  ctrl_reach_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_req_s |=> wr_pend) else $error("control write refused");
  pin_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> tx_out && rts_n && dtr_n && !int_oe && irq_n) else $error("pins after reset");
  // only power-up reloads the divisor; the pin reset is checked above
  div_powerup_a: assert property (@(posedge hclk) disable iff (!por_n)
    $rose(por_n) |-> divlo == `UFC_RST_DIVLO && divhi == `UFC_RST_DIVHI) else $error("divisor power-up");
endmodule // ufc_bank

// *** hw/ufc_consts.svh ***
`ifndef UFC_CONSTS_SVH
`define UFC_CONSTS_SVH
// ----------------------------------------
// register word offsets (byte addresses)
// ----------------------------------------
`define UFC_OFF_RESUME1   12'h000
`define UFC_OFF_RESUME2   12'h004
`define UFC_OFF_PAUSE1    12'h008
`define UFC_OFF_PAUSE2    12'h00c
`define UFC_OFF_DIVLO     12'h010
`define UFC_OFF_DIVHI     12'h014
`define UFC_OFF_FRAC      12'h018
`define UFC_OFF_IER       12'h01c
`define UFC_OFF_FCR       12'h020
`define UFC_OFF_ISR       12'h024
`define UFC_OFF_LCR       12'h028
`define UFC_OFF_MCR       12'h02c
`define UFC_OFF_LSR       12'h030
`define UFC_OFF_MSR       12'h034
`define UFC_OFF_SPR       12'h038
`define UFC_OFF_ENHANCED_MODE_SELECT_REG      12'h03c
`define UFC_OFF_FEATURE_CONTROL_REG      12'h040
`define UFC_OFF_EFR       12'h044
`define UFC_OFF_CTRL      12'h048
// ----------------------------------------
// reset values and bit positions
// ----------------------------------------
`define UFC_RST_ZERO      8'h00
`define UFC_RST_DIVLO     8'h01
`define UFC_RST_DIVHI     8'h00
`define UFC_RST_ISR       8'h01
`define UFC_RST_LSR       8'h60
`define UFC_RST_SPR       8'hff
`define UFC_ISR_SPECIAL   4
`define UFC_EFR_SPECIAL   5
`define UFC_CTRL_MULTIDROP 0
`define UFC_CTRL_PWRSAVE  1
`define UFC_MCR_DTR       0
`define UFC_MCR_RTS       1
`define UFC_MCR_INTEN     3
`define UFC_IER_SPECIAL   5
`endif

// *** hw/ufc_pkg.sv ***
package ufc_pkg;
  typedef enum logic [1:0] {UFC_IDLE, UFC_DATA} ufc_phase_t;
  typedef logic [7:0] ufc_byte_t;
endpackage

// *** hw/ufc_rx_if.sv ***
`timescale 1ns/100ps
interface ufc_rx_if;
  logic              valid;
  ufc_pkg::ufc_byte_t data;
  logic              addr_bit;
  ufc_pkg::ufc_byte_t pause_two;
  logic              special_en;
  logic              multidrop_en;
  logic              special_hit;
  logic              addr_hit;
  modport bank (output pause_two, special_en, multidrop_en, input special_hit, addr_hit);
  modport cmp  (input valid, data, addr_bit, pause_two, special_en, multidrop_en, output special_hit, addr_hit);
endinterface

// *** hw/ufc_rx_match.sv ***
`timescale 1ns/100ps
module ufc_rx_match (
  ufc_rx_if.cmp rx
);
  // ----------------------------------------
  // compare of received characters
  // ----------------------------------------
  assign rx.special_hit = rx.valid && rx.special_en && !rx.addr_bit && (rx.data == rx.pause_two);
  assign rx.addr_hit    = rx.valid && rx.multidrop_en && rx.addr_bit && (rx.data == rx.pause_two);
endmodule // ufc_rx_match

// *** sim/ufc_host.sv ***
`timescale 1ns/100ps
module ufc_host (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [11:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // ----------------------------------------
  // one single word transfer, waits for the slave
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
endmodule // ufc_host

// *** sim/uart_flow_chars_and_reset_state_tb.sv ***
`timescale 1ns/100ps
module uart_flow_chars_and_reset_state_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        por_n = 1'b0;
  logic [3:0]  modem_in = 4'ha;
  logic        rx_valid = 1'b0;
  logic [7:0]  rx_data = 8'h00;
  logic        rx_addr_bit = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp, rx_store, rx_addr_match;
  logic        tx_out, rts_n, dtr_n, int_out, int_oe, irq_n;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  int          error_cnt = 0;
  int          n_tests = 0;
  // address in 19:8, reset value in 7:0; last row is unmapped
  logic [19:0] rows[19] = '{20'h00000, 20'h00400, 20'h00800, 20'h00c00, 20'h01001, 20'h01400,
    20'h01800, 20'h01c00, 20'h02000, 20'h02401, 20'h02800, 20'h02c00, 20'h03060, 20'h034a0,
    20'h038ff, 20'h03c00, 20'h04000, 20'h04400, 20'h10000};
  always #4 hclk = ~hclk;
  ufc_bank DUT (.hclk, .hresetn, .por_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .modem_in, .rx_valid, .rx_data,
    .rx_addr_bit, .rx_store, .rx_addr_match, .tx_out, .rts_n, .dtr_n, .int_out, .int_oe, .irq_n);
  ufc_host host (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    host.xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    host.xfer(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  // one received character; match flag in bit 1, store in bit 0
  task automatic rx(input logic [7:0] d, input logic b, input logic [1:0] exp);
    @(posedge hclk);
    rx_valid <= 1'b1;
    rx_data <= d;
    rx_addr_bit <= b;
    @(negedge hclk);
    chk(32'({rx_addr_match, rx_store}), 32'(exp));
    @(posedge hclk);
    rx_valid <= 1'b0;
  endtask
  task automatic test_done();
    $display("checks=%0d errors=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    @(negedge hclk);
    chk(32'({tx_out, rts_n, dtr_n, int_oe, irq_n}), 32'h1d);
    foreach (rows[i]) begin
      rd(rows[i][19:8], 32'(rows[i][7:0]));
    end
    for (int i = 0; i < 4; i++) begin
      wr(12'(4 * i), {24'hffffff, 8'h3c + 8'(i)});
    end
    for (int i = 0; i < 4; i++) begin
      rd(12'(4 * i), 32'(8'h3c + 8'(i)));
    end
    // divisor survives the pin reset, only power-up reloads it
    wr(12'h010, 32'h05);
    wr(12'h014, 32'h07);
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    rd(12'h010, 32'h05);
    rd(12'h014, 32'h07);
    rd(12'h000, 32'h00);
    por_n <= 1'b0;
    @(posedge hclk);
    por_n <= 1'b1;
    rd(12'h010, 32'h01);
    rd(12'h014, 32'h00);
    modem_in <= 4'h5;
    rd(12'h034, 32'h50);
    wr(12'h034, 32'hff);
    rd(12'h034, 32'h50);
    wr(12'h00c, 32'h5a);
    rx(8'h5a, 1'b1, 2'h0);
    wr(12'h048, 32'h01);
    rx(8'h5a, 1'b1, 2'h2);
    rx(8'h5b, 1'b1, 2'h0);
    rd(12'h024, 32'h01);
    wr(12'h048, 32'h00);
    wr(12'h044, 32'h20);
    rx(8'h5b, 1'b0, 2'h1);
    rd(12'h024, 32'h01);
    rx(8'h5a, 1'b0, 2'h1);
    rd(12'h024, 32'h11);
    wr(12'h01c, 32'h20);
    wr(12'h02c, 32'h0b);
    @(negedge hclk);
    chk(32'({hreadyout, hresp, int_out, irq_n, int_oe, rts_n, dtr_n}), 32'h54);
    wr(12'h024, 32'h00);
    rd(12'h024, 32'h01);
    @(negedge hclk);
    chk(32'({int_out, irq_n}), 32'h1);
    // power-save: only the control word is reachable
    rx_valid <= 1'b0;
    wr(12'h048, 32'h02);
    wr(12'h000, 32'h77);
    rd(12'h048, 32'h02);
    rd(12'h038, 32'h02);
    wr(12'h048, 32'h00);
    rd(12'h000, 32'h00);
    test_done();
  end
  initial begin
    #50000;
    error_cnt++;
    test_done();
  end
endmodule // uart_flow_chars_and_reset_state_tb
